// file: usi_pkg.sv
// Constants and types shared by the serial shift unit
package usi_pkg;
  // ==========================================================
  // Widths, positions and reset values
  localparam int DATA_W = 8;
  localparam int CNT_W = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int MSB_POS = 7;
  localparam int DIR_DATA = 0;
  localparam int DIR_CLK = 1;
  localparam logic [CNT_W-1:0] CNT_MAX = 4'hF;
  localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
  localparam logic [CNT_W-1:0] CNT_STEP = 4'h1;

  // ==========================================================
  // Modes and carriers
  typedef enum logic [1:0] {WM_OFF, WM_THREE, WM_TWO} wire_mode_e;

  typedef struct packed {
    wire_mode_e wire_mode;
    logic external_clock_select;
    logic clock_edge_select;
    logic software_clock_strobe;
    logic clock_toggle_strobe;
  } ctrl_s;

  typedef struct packed {
    logic ovf_clear;
    logic [CNT_W-1:0] cnt;
  } status_wr_s;

  typedef struct packed {
    logic o;
    logic oe;
  } pin_out_s;

  typedef struct packed {
    ctrl_s cfg;
    logic [DATA_W-1:0] sr;
    logic [CNT_W-1:0] cnt;
    logic ovf;
    logic latch;
    logic clk_port;
    logic [2:0] ck_s;
    logic [2:0] di_s;
    logic ck_f;
    logic di_f;
    logic pend;
    logic [DATA_W-1:0] pend_byte;
  } state_s;

  localparam state_s STATE_RST = '0;
endpackage : usi_pkg

// file: usi_core.sv
// Serial shift unit core with its receive FIFO
`timescale 1ns/100ps

// ==========================================================
// Receive FIFO
module shift_fifo
  import usi_pkg::*;
#(
  parameter int W = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
)(
  input wire logic ref_clk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic in_valid, // Producer has a word
  output logic in_ready, // Room for a word
  input wire logic [W-1:0] in_data, // Word to store
  output logic out_valid, // A word is waiting
  input wire logic out_ready, // Consumer takes it
  output logic [W-1:0] out_data // Oldest word
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } fifo_s;
  fifo_s f_q;
  fifo_s f_d;
  logic push;
  logic pop;

  // Pointer step that also copes with a depth not a power of two
  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : next_ptr

  // Handshakes from the occupancy count
  assign in_ready = (f_q.cnt != CW'(DEPTH));
  assign out_valid = (f_q.cnt != '0);
  assign out_data = f_q.mem[f_q.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Next state
  always_comb
  begin
    f_d = f_q;
    if (push)
    begin
      f_d.mem[f_q.wp] = in_data;
      f_d.wp = next_ptr(f_q.wp);
    end
    if (pop)
      f_d.rp = next_ptr(f_q.rp);
    f_d.cnt = f_q.cnt + CW'(push) - CW'(pop);
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      f_q <= '0;
    else
      f_q <= f_d;
  end
endmodule : shift_fifo

// ==========================================================
// Shift unit
module usi_core
  import usi_pkg::*;
(
  input wire logic ref_clk, // System clock, 20 MHz
  input wire logic rst, // Async reset, high
  input wire logic ctrl_wr, // Control write strobe
  input wire ctrl_s ctrl_in, // Control write value
  input wire logic data_wr, // Shift register write strobe
  input wire logic [DATA_W-1:0] data_in, // Shift register write value
  input wire logic status_wr, // Status write strobe
  input wire status_wr_s status_in, // Status write value
  input wire logic [1:0] port_direction_register, // Pin drive enables
  input wire logic serial_data_in_pin, // Data input or data line level
  input wire logic serial_clock_pin, // Clock line level
  output pin_out_s clock_pin_out, // Clock pin drive
  output pin_out_s data_pin_out, // Data pin drive
  output logic [DATA_W-1:0] shift_data_register, // Shift register
  output logic [CNT_W-1:0] counter_value, // Edge counter
  output logic counter_overflow_flag, // Sticky overflow flag
  output logic idle_wake, // Wake from idle sleep
  output logic rx_valid, // Received byte waiting
  input wire logic rx_ready, // Received byte taken
  output logic [DATA_W-1:0] rx_byte // Oldest received byte
);
  state_s st_q;
  state_s st_d;
  logic nck;
  logic ndi;
  logic rise;
  logic fall;
  logic ext;
  logic samp_edge;
  logic sw_clk;
  logic tgl;
  logic shift_en;
  logic cnt_en;
  logic wrap;
  logic transparent;
  logic hold;
  logic push_ready;
  wire_mode_e wm;

  // ==========================================================
  // Link sampling and clock source decode
  // Filtered levels move only when the second and third stages agree
  assign nck = (st_q.ck_s[2] == st_q.ck_s[1]) ? st_q.ck_s[2] : st_q.ck_f;
  assign ndi = (st_q.di_s[2] == st_q.di_s[1]) ? st_q.di_s[2] : st_q.di_f;
  assign rise = nck & ~st_q.ck_f;
  assign fall = ~nck & st_q.ck_f;
  assign ext = st_q.cfg.external_clock_select;
  assign wm = st_q.cfg.wire_mode;
  // Choice of sampling edge; two-wire users pick falling-edge shift
  assign samp_edge = ext & (st_q.cfg.clock_edge_select ? fall : rise);
  assign sw_clk = ctrl_wr & ctrl_in.software_clock_strobe;
  assign tgl = ctrl_wr & ctrl_in.clock_toggle_strobe;
  // Strobe decisions use the bits of the write that carries them
  assign shift_en = samp_edge | (sw_clk & ~ctrl_in.external_clock_select);
  assign cnt_en = (ext & ~st_q.cfg.software_clock_strobe & (rise | fall))
    | (sw_clk & (~ctrl_in.external_clock_select | ctrl_in.clock_toggle_strobe));
  assign wrap = cnt_en & ~status_wr & (st_q.cnt == CNT_MAX);
  // Latch open in first half of an external cycle, always otherwise
  assign transparent = ~ext | (st_q.cfg.clock_edge_select ? nck : ~nck);
  // Slave holds clock low on overflow or while its byte cannot be stored
  assign hold = (wm == WM_TWO) & (st_q.ovf | st_q.pend);

  // ==========================================================
  // Next state
  always_comb
  begin
    st_d = st_q;
    st_d.ck_s = {st_q.ck_s[1:0], serial_clock_pin};
    st_d.di_s = {st_q.di_s[1:0], serial_data_in_pin};
    st_d.ck_f = nck;
    st_d.di_f = ndi;
    // Mode bits are kept; the toggle strobe acts once and is not stored
    if (ctrl_wr)
    begin
      st_d.cfg = ctrl_in;
      st_d.cfg.clock_toggle_strobe = 1'b0;
    end
    if (tgl)
      st_d.clk_port = ~st_q.clk_port;
    // A write beats a shift in the same cycle; no buffering behind it
    if (data_wr)
      st_d.sr = data_in;
    else if (shift_en)
      st_d.sr = {st_q.sr[MSB_POS-1:0], ndi};
    // Counter write wins over a counting edge
    if (status_wr)
      st_d.cnt = status_in.cnt;
    else if (cnt_en)
      st_d.cnt = st_q.cnt + CNT_STEP;
    // A status write blocks the flag set, so a clear arriving in the same cycle wins
    if (status_wr & status_in.ovf_clear)
      st_d.ovf = 1'b0;
    if (wrap)
      st_d.ovf = 1'b1;
    // Newly written MSB shows at once while the latch is open
    if (transparent)
      st_d.latch = st_d.sr[MSB_POS];
    // Completed byte waits here until the FIFO has room
    if (st_q.pend & push_ready)
      st_d.pend = 1'b0;
    if (wrap)
    begin
      st_d.pend = 1'b1;
      st_d.pend_byte = st_d.sr;
    end
  end

  // State register; the first sync stage feeds only the second
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      st_q <= STATE_RST;
    else
      st_q <= st_d;
  end

  // ==========================================================
  // Pin drive
  // Two-wire pins are open drain: drive low or release, no slew shaping
  assign clock_pin_out.o = (wm == WM_THREE) & st_q.clk_port;
  assign clock_pin_out.oe = (wm == WM_THREE) ? port_direction_register[DIR_CLK]
    : (wm == WM_TWO) & ((port_direction_register[DIR_CLK] & ~st_q.clk_port) | hold);
  assign data_pin_out.o = (wm == WM_THREE) & st_q.latch;
  assign data_pin_out.oe = (wm == WM_THREE) ? port_direction_register[DIR_DATA]
    : (wm == WM_TWO) & port_direction_register[DIR_DATA] & ~st_q.latch;

  // Status outputs straight from registers
  assign shift_data_register = st_q.sr;
  assign counter_value = st_q.cnt;
  assign counter_overflow_flag = st_q.ovf;
  assign idle_wake = st_q.ovf;

  // Received bytes queue here; a full queue stretches a two-wire clock
  shift_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) rx_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(st_q.pend),
    .in_ready(push_ready),
    .in_data(st_q.pend_byte),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_byte)
  );

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_last_edge;
    cnt_en && !status_wr && (st_q.cnt == CNT_MAX);
  endsequence
  sequence s_flag_up;
    st_q.ovf && (st_q.cnt == CNT_RST);
  endsequence
  sequence s_open_high;
    ext && !st_q.cfg.clock_edge_select && nck;
  endsequence

  a_overflow_set:
    assert property (s_last_edge |=> s_flag_up)
    else $error("overflow flag not set on counter wrap");
  a_both_edges:
    assert property (ext && !st_q.cfg.software_clock_strobe && (rise || fall) && !ctrl_wr && !status_wr
      |=> st_q.cnt == CNT_W'($past(st_q.cnt) + CNT_STEP))
    else $error("external edge did not count once");
  a_status_clear:
    assert property (status_wr && status_in.ovf_clear |=> !st_q.ovf && st_q.cnt == $past(status_in.cnt))
    else $error("status write did not clear flag and load count");
  a_rise_sample:
    assert property (ext && !st_q.cfg.clock_edge_select && rise && !data_wr
      |=> st_q.sr == {$past(st_q.sr[MSB_POS-1:0]), $past(ndi)})
    else $error("no shift on rising edge");
  a_fall_sample:
    assert property (ext && st_q.cfg.clock_edge_select && fall && !data_wr
      |=> st_q.sr == {$past(st_q.sr[MSB_POS-1:0]), $past(ndi)})
    else $error("no shift on falling edge");
  a_latch_closed:
    assert property (s_open_high |=> $stable(st_q.latch))
    else $error("output latch moved in second half");
  a_toggle_count:
    assert property (tgl && ctrl_in.external_clock_select && ctrl_in.software_clock_strobe && !status_wr
      |=> st_q.clk_port != $past(st_q.clk_port) && st_q.cnt == CNT_W'($past(st_q.cnt) + CNT_STEP))
    else $error("toggle write did not toggle and count once");
  a_strobe_shift:
    assert property (sw_clk && !ctrl_in.external_clock_select && !data_wr
      |=> st_q.sr == {$past(st_q.sr[MSB_POS-1:0]), $past(ndi)})
    else $error("software strobe did not shift");
  a_hold_low:
    assert property (wm == WM_TWO && st_q.ovf |-> clock_pin_out.oe && !clock_pin_out.o)
    else $error("clock not held low on two-wire overflow");
  a_count_write:
    assert property (status_wr ##1 !status_wr && !cnt_en |=> st_q.cnt == $past(status_in.cnt, 2))
    else $error("counter write lost");
  a_three_wire:
    assert property (wm == WM_THREE |-> data_pin_out.o == st_q.latch
      && data_pin_out.oe == port_direction_register[DIR_DATA])
    else $error("three-wire data pin wrong");
  a_hold_release:
    assert property (wm == WM_TWO && status_wr && status_in.ovf_clear && !wrap && !st_q.pend |=> !hold)
    else $error("flag clear did not release the clock");
  a_write_wins:
    assert property (status_wr && cnt_en |=> st_q.cnt == $past(status_in.cnt) && !$rose(st_q.ovf))
    else $error("count edge beat a counter write");
endmodule : usi_core

// file: spi_master_model.sv
// Behavioural three-wire master that clocks the shift unit from outside
`timescale 1ns/100ps
// ==========================================================
// Master model
module spi_master_model (
  output logic sclk, // Serial clock it makes
  output logic mosi, // Data it sends
  input wire logic miso // Data it receives
);
  // Clock stands still low between frames
  initial
  begin
    sclk = 1'b0;
    mosi = 1'b0;
  end

  // One byte MSB first, 400 ns a bit; late sampling allows for the unit's synchronizer lag
  task automatic xfer(input logic m1, input logic [7:0] tx, output logic [7:0] rx);
    // Mode 0 puts its first bit out half a clock ahead of the first rise
    if (!m1)
    begin
      mosi = tx[7];
      #200;
    end
    for (int i = 7; i >= 0; i--)
    begin
      sclk = 1'b1;
      if (m1) mosi = tx[i];
      #190 if (!m1) rx[i] = miso;
      #10 sclk = 1'b0;
      if (!m1 && i > 0) mosi = tx[i - 1];
      #190 if (m1) rx[i] = miso;
      #10;
    end
    // Inverted idle level so a stale bit cannot pass
    mosi = ~mosi;
  endtask : xfer
endmodule : spi_master_model

// file: universal_serial_shift_unit_tb_top.sv
// Self-checking bench for the serial shift unit
`timescale 1ns/100ps
// ==========================================================
// Bench top
module universal_serial_shift_unit_tb_top
  import usi_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ctrl_wr = 1'b0;
  logic data_wr = 1'b0;
  logic status_wr = 1'b0;
  logic rx_ready = 1'b0;
  logic two = 1'b0;
  ctrl_s ctrl_in = '0;
  status_wr_s status_in = '0;
  logic [7:0] data_in = 8'h00;
  logic [1:0] dir = 2'h1;
  pin_out_s ck_o, dt_o;
  logic [7:0] sr, rxb, got, d, t;
  logic [3:0] cnt;
  logic ovf, wake, rxv, sclk, mosi, sck_w, di_w, ck0;
  logic [31:0] rnd = 32'h2AD7;
  logic [7:0] q[$];
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  int n;

  always #25 ref_clk = ~ref_clk;

  // Pin levels resolved from the unit's enables; two-wire lines pull up when released
  assign sck_w = ck_o.oe ? ck_o.o : (two | sclk);
  // Bench leaves the two-wire data line to the unit alone
  assign di_w = two ? (!dt_o.oe | dt_o.o) : mosi;

  usi_core DUT (
    .ref_clk(ref_clk), .rst(rst), .ctrl_wr(ctrl_wr), .ctrl_in(ctrl_in), .data_wr(data_wr),
    .data_in(data_in), .status_wr(status_wr), .status_in(status_in), .port_direction_register(dir),
    .serial_data_in_pin(di_w), .serial_clock_pin(sck_w), .clock_pin_out(ck_o), .data_pin_out(dt_o),
    .shift_data_register(sr), .counter_value(cnt), .counter_overflow_flag(ovf), .idle_wake(wake),
    .rx_valid(rxv), .rx_ready(rx_ready), .rx_byte(rxb)
  );

  spi_master_model master (.sclk(sclk), .mosi(mosi), .miso(dt_o.oe ? dt_o.o : 1'bz));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One write; k picks control, data, status strobes; two cycles so strobes never rise twice at once
  task automatic wr(input logic [2:0] k, input logic [7:0] v, input ctrl_s c);
    @(posedge ref_clk);
    {ctrl_wr, data_wr, status_wr} <= k;
    ctrl_in <= c;
    data_in <= v;
    status_in <= v[4:0];
    @(posedge ref_clk);
    {ctrl_wr, data_wr, status_wr} <= 3'h0;
  endtask : wr

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // Cut a hang short
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      fails++;
      close_out();
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk("reset sr", sr, 8'h00);
    chk("reset flags", {cnt, ovf, rxv, ck_o.oe, dt_o.oe}, 8'h00);
    // Slave exchanges, both edge modes, configured once per mode
    for (int m = 0; m < 2; m++)
    begin
      wr(3'h4, 8'h00, m ? 6'h1C : 6'h18);
      for (int k = 0; k < 2; k++)
      begin
        rnd = lfsr(rnd);
        d = rnd[7:0];
        t = rnd[15:8];
        wr(3'h2, d, '0);
        wr(3'h1, 8'h10, '0);
        #7 master.xfer(m[0], t, got);
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("slave sr", sr, t);
        chk("master rx", got, d);
        chk("count flag", 8'({cnt, ovf, wake}), 8'h03);
        chk("rx byte", rxb, t);
        chk("rx valid", 8'(rxv), 8'h01);
        @(posedge ref_clk);
        rx_ready <= 1'b1;
        @(posedge ref_clk);
        rx_ready <= 1'b0;
      end
    end
    // Slave lets its data output float once its direction bit is cleared
    @(posedge ref_clk);
    dir <= 2'h0;
    @(negedge ref_clk);
    chk("data float", 8'(dt_o.oe), 8'h00);
    // Counter load keeps the flag unless the clear bit is set
    wr(3'h1, 8'h0F, '0);
    @(negedge ref_clk);
    chk("load keep", 8'({cnt, ovf}), 8'h1F);
    wr(3'h1, 8'h15, '0);
    @(negedge ref_clk);
    chk("load clear", 8'({cnt, ovf}), 8'h0A);
    // Fast master: toggle, then toggle plus strobe, eight times
    @(posedge ref_clk);
    dir <= 2'h3;
    rnd = lfsr(rnd);
    wr(3'h2, rnd[7:0], '0);
    wr(3'h1, 8'h10, '0);
    wr(3'h4, 8'h00, 6'h10);
    // Latch opens with the stored mode, so it follows one cycle later
    repeat (2) @(negedge ref_clk);
    chk("out bit", 8'(dt_o.o), 8'(rnd[7]));
    ck0 = ck_o.o;
    repeat (8)
    begin
      wr(3'h4, 8'h00, 6'h11);
      wr(3'h4, 8'h00, 6'h13);
    end
    @(negedge ref_clk);
    chk("fast sr", sr, {8{mosi}});
    chk("fast count", 8'({cnt, ovf, ck_o.o}), 8'({4'h8, 1'b0, ck0}));
    // External clock with software strobe counts toggle writes only
    wr(3'h1, 8'h10, '0);
    repeat (3) wr(3'h4, 8'h00, 6'h1B);
    @(negedge ref_clk);
    chk("strobe count", 8'({cnt, ck_o.o}), 8'({4'h3, ~ck0}));
    repeat (8) @(posedge ref_clk);
    // Nine wraps with the consumer stalled: eight fill the buffer, one waits
    for (int k = 0; k < 9; k++)
    begin
      rnd = lfsr(rnd);
      wr(3'h2, rnd[7:0], '0);
      wr(3'h1, 8'h0F, '0);
      wr(3'h4, 8'h00, 6'h12);
      q.push_back({rnd[6:0], mosi});
    end
    n = 0;
    repeat (14)
    begin
      @(negedge ref_clk);
      if (rxv === 1'b1)
      begin
        chk("drain byte", rxb, q.pop_front());
        n++;
        @(posedge ref_clk);
        rx_ready <= 1'b1;
        @(posedge ref_clk);
        rx_ready <= 1'b0;
      end
    end
    chk("drain count", 8'(n), 8'h09);
    // Counter write and strobe count together: write wins, no wrap, flag cleared
    wr(3'h5, 8'h1F, 6'h12);
    @(negedge ref_clk);
    chk("write wins", 8'({cnt, ovf}), 8'h1E);
    // Two-wire overflow holds the clock low until the flag is cleared
    @(posedge ref_clk);
    two <= 1'b1;
    wr(3'h1, 8'h0F, '0);
    wr(3'h4, 8'h00, 6'h22);
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("hold", 8'({ck_o.oe, ck_o.o}), 8'h02);
    wr(3'h1, 8'h10, '0);
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("release", 8'(ck_o.oe), 8'h00);
    chk("line high", 8'(sck_w), 8'h01);
    close_out();
  end
endmodule : universal_serial_shift_unit_tb_top
